// ### src/rtcs_pkg.sv
/*
  Shared constants for the two-wire slave port of the clock/calendar block.
  Assumes nothing of its surroundings; included by every design file.
*/
package rtcs_pkg;
  localparam int RTCS_BYTE_BITS = 8;
  localparam int RTCS_PTR_BITS = 4;
  localparam int RTCS_SYNC_STAGES = 2;
  localparam logic [3:0] RTCS_CNT_FULL = 4'h8;
  localparam logic [3:0] RTCS_CNT_RESET = 4'h0;
  localparam logic [3:0] RTCS_PTR_RESET = 4'h0;
  localparam logic [6:0] RTCS_SLAVE_ADDR_DEFAULT = 7'h2a;

  typedef enum logic [2:0] {
    RTCS_IDLE = 3'b000,
    RTCS_RX   = 3'b001,
    RTCS_ACK  = 3'b010,
    RTCS_TX   = 3'b011,
    RTCS_MACK = 3'b100,
    RTCS_NEXT = 3'b101
  } rtcs_state_t;

  typedef enum logic [1:0] {
    RTCS_KIND_ADDR = 2'b00,
    RTCS_KIND_WORD = 2'b01,
    RTCS_KIND_DATA = 2'b10
  } rtcs_kind_t;
endpackage : rtcs_pkg

// ### src/rtcs_sync.sv
/*
  Multi-stage synchroniser for asynchronous pin levels.
  Assumes the destination clock is much faster than the pin's toggle rate.
*/
`timescale 1ns/100ps
`default_nettype none
module rtcs_sync
  import rtcs_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter int STAGES = RTCS_SYNC_STAGES,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  // a single stage would let a metastable level reach the logic
  if (STAGES < 2) begin : g_bad_stages
    $error("rtcs_sync needs at least two stages");
  end

  // only the last stage is visible outside; earlier stages may be metastable
  logic [WIDTH-1:0] stage [STAGES];

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < STAGES; i++) begin
        stage[i] <= INIT;
      end
    end else begin
      stage[0] <= d;
      for (int i = 1; i < STAGES; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign q = stage[STAGES-1];
endmodule : rtcs_sync
`default_nettype wire

// ### src/rtcs_slave_port.sv
/*
  Two-wire serial slave port: address match, word-address pointer, register
  write and read strobes toward the clock/calendar register file.
  Assumes a register file on CLOCK that answers REG_RDATA combinationally
  from REG_PTR, and bus pins that are oversampled by CLOCK (50 MHz).
*/
// Operation
// - no limit on bytes between START and STOP
// - every byte is eight bits plus ack
// - addressed receiver acknowledges every received byte
// - acknowledger holds data low through clock high
// - after NACK device releases data, stops sending
// - first byte after START selects slave
// - clock is input only; data is bidirectional
// - 4-bit pointer picks next accessed register
// - high nibble of word address ignored
// - START/STOP are data edges while clock high
// - data changes only while clock low
`timescale 1ns/100ps
`default_nettype none
module rtcs_slave_port
  import rtcs_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = RTCS_SLAVE_ADDR_DEFAULT // arbitrary value
) (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic [RTCS_PTR_BITS-1:0] REG_PTR,
  output logic [RTCS_BYTE_BITS-1:0] REG_WDATA,
  output logic REG_WRITE,
  output logic REG_READ,
  input wire logic [RTCS_BYTE_BITS-1:0] REG_RDATA,
  output logic BUSY
);
  // the pointer is taken from the low bits of one received byte
  if (RTCS_PTR_BITS > RTCS_BYTE_BITS) begin : g_bad_ptr
    $error("pointer wider than a byte");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and bus conditions

  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;

  // the clock pin is only ever sampled, never driven
  rtcs_sync #(.WIDTH(2), .STAGES(RTCS_SYNC_STAGES), .INIT(2'h3)) u_sync (
    .clk(CLOCK),
    .srst(SRST),
    .d({SCL, SDA_IN}),
    .q({scl_s, sda_s})
  );

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  // a data edge while the clock stays high is a condition, not a bit
  wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // byte engine

  rtcs_state_t state;
  rtcs_state_t next_state;
  rtcs_kind_t kind;
  rtcs_kind_t next_kind;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [RTCS_BYTE_BITS-1:0] shreg;
  logic [RTCS_BYTE_BITS-1:0] next_shreg;
  logic [RTCS_PTR_BITS-1:0] next_ptr;
  logic rw;
  logic next_rw;
  logic next_oe;
  logic next_write;
  logic next_read;

  wire byte_in = (state == RTCS_RX) && scl_fall && (bit_cnt == RTCS_CNT_FULL);
  wire addr_match = (shreg[7:1] == SLAVE_ADDR);
  wire ack_end = (state == RTCS_ACK) && scl_fall;
  wire tx_last = (bit_cnt == RTCS_CNT_FULL - 4'h1);

  always_comb begin
    next_state = state;
    next_kind = kind;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_ptr = REG_PTR;
    next_rw = rw;
    next_oe = SDA_OE;
    next_write = 1'b0;
    next_read = 1'b0;
    if (start_cond) begin
      // also a repeated start; the first byte is always an address
      next_state = RTCS_RX;
      next_kind = RTCS_KIND_ADDR;
      next_bit_cnt = RTCS_CNT_RESET;
      next_oe = 1'b0;
    end else if (stop_cond) begin
      next_state = RTCS_IDLE;
      next_oe = 1'b0;
    end else begin
      case (state)
        RTCS_IDLE: begin
          next_oe = 1'b0;
        end
        RTCS_RX: begin
          if (scl_rise && bit_cnt != RTCS_CNT_FULL) begin
            next_shreg = {shreg[RTCS_BYTE_BITS-2:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (byte_in) begin
            next_state = RTCS_ACK;
            next_oe = 1'b1;
            case (kind)
              RTCS_KIND_ADDR: begin
                if (addr_match) begin
                  next_rw = shreg[0];
                end else begin
                  next_state = RTCS_IDLE;
                  next_oe = 1'b0;
                end
              end
              RTCS_KIND_WORD: begin
                next_ptr = shreg[RTCS_PTR_BITS-1:0];
              end
              default: begin
                next_write = 1'b1;
              end
            endcase
          end
        end
        RTCS_ACK: begin
          // low is held until the falling edge ending the ack pulse
          if (scl_fall) begin
            next_bit_cnt = RTCS_CNT_RESET;
            if (kind == RTCS_KIND_ADDR && rw) begin
              next_state = RTCS_TX;
              next_shreg = REG_RDATA;
              next_read = 1'b1;
              next_oe = ~REG_RDATA[RTCS_BYTE_BITS-1];
            end else begin
              next_state = RTCS_RX;
              next_oe = 1'b0;
              // after the word address every byte is data, with no limit
              next_kind = (kind == RTCS_KIND_ADDR) ? RTCS_KIND_WORD : RTCS_KIND_DATA;
            end
          end
        end
        RTCS_TX: begin
          if (scl_fall) begin
            if (tx_last) begin
              next_state = RTCS_MACK;
              next_oe = 1'b0;
              next_ptr = REG_PTR + 4'h1;
            end else begin
              next_shreg = {shreg[RTCS_BYTE_BITS-2:0], 1'b0};
              next_oe = ~shreg[RTCS_BYTE_BITS-2];
              next_bit_cnt = bit_cnt + 4'h1;
            end
          end
        end
        RTCS_MACK: begin
          if (scl_rise) begin
            // a missing ack ends the read; stay off the line for the stop
            next_state = sda_s ? RTCS_IDLE : RTCS_NEXT;
          end
        end
        RTCS_NEXT: begin
          if (scl_fall) begin
            next_state = RTCS_TX;
            next_bit_cnt = RTCS_CNT_RESET;
            next_shreg = REG_RDATA;
            next_read = 1'b1;
            next_oe = ~REG_RDATA[RTCS_BYTE_BITS-1];
          end
        end
        default: begin
          next_state = RTCS_IDLE;
          next_oe = 1'b0;
        end
      endcase
    end
  end

  // a write strobe advances the pointer one cycle later, so the strobe
  // still sees the target address
  wire [RTCS_PTR_BITS-1:0] ptr_d = REG_WRITE ? REG_PTR + 4'h1 : next_ptr;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state <= RTCS_IDLE;
      kind <= RTCS_KIND_ADDR;
      bit_cnt <= RTCS_CNT_RESET;
      shreg <= '0;
      rw <= 1'b0;
      SDA_OE <= 1'b0;
      REG_PTR <= RTCS_PTR_RESET;
      REG_WRITE <= 1'b0;
      REG_READ <= 1'b0;
      REG_WDATA <= '0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      rw <= next_rw;
      SDA_OE <= next_oe;
      REG_PTR <= ptr_d;
      REG_WRITE <= next_write;
      REG_READ <= next_read;
      if (next_write) begin
        REG_WDATA <= shreg;
      end
    end
  end

  // open drain: only ever pulls low
  assign SDA_OUT = 1'b0;
  assign BUSY = (state != RTCS_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  a_addr_ack_drive: assert property (
    byte_in && kind == RTCS_KIND_ADDR && addr_match && !start_cond && !stop_cond
      |=> SDA_OE && state == RTCS_ACK)
    else $error("matching address not acknowledged");

  a_foreign_addr_quiet: assert property (
    byte_in && kind == RTCS_KIND_ADDR && !addr_match && !start_cond && !stop_cond
      |=> !SDA_OE && state == RTCS_IDLE)
    else $error("foreign address answered");

  a_ptr_low_nibble: assert property (
    byte_in && kind == RTCS_KIND_WORD && !start_cond && !stop_cond
      |=> REG_PTR == $past(shreg[3:0]))
    else $error("pointer not loaded from low nibble");

  a_write_advance: assert property (
    REG_WRITE |=> REG_PTR == $past(REG_PTR) + 4'h1)
    else $error("pointer did not advance after write");

  a_nack_release: assert property (
    state == RTCS_MACK && scl_rise && sda_s && !start_cond && !stop_cond
      |=> !SDA_OE && state == RTCS_IDLE ##1 !REG_READ)
    else $error("data line held after missing ack");

  a_stop_idle: assert property (
    stop_cond |=> state == RTCS_IDLE && !SDA_OE)
    else $error("stop condition not honoured");

  a_ack_held_high: assert property (
    state == RTCS_ACK && scl_s |-> SDA_OE)
    else $error("ack released while clock high");

  a_bit_count: assert property (
    bit_cnt <= RTCS_CNT_FULL)
    else $error("more than eight bits in a byte");

  a_read_direction: assert property (
    ack_end && kind == RTCS_KIND_ADDR && rw && !start_cond && !stop_cond
      |=> state == RTCS_TX && REG_READ)
    else $error("read bit did not start transmission");

  a_oe_stable_high: assert property (
    state == RTCS_TX && scl_s && scl_d |-> $stable(SDA_OE))
    else $error("data changed while clock high");

  c_write_byte: cover property (REG_WRITE);
  c_read_two: cover property (REG_READ ##[1:1000] REG_READ);
  c_nack_end: cover property (state == RTCS_MACK && scl_rise && sda_s);
  c_repeat_start: cover property (state == RTCS_RX && kind == RTCS_KIND_DATA ##1 start_cond);
endmodule : rtcs_slave_port
`default_nettype wire

// ### verification/rtcs_master_model.sv
/*
  Behavioural two-wire bus master that faces the slave port.
  Assumes an open-drain data wire with a pull-up, built by the bench from
  sda_drv and the device's enable, and fed back here as sda_wire.
*/
`timescale 1ns/100ps
`default_nettype none
module rtcs_master_model
  import rtcs_pkg::*;
(
  input wire logic lclk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_drv
);
  // serial clock stands high between frames; released data reads as pull-up
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
  endtask : tick

  // data moves only mid-low; sampled mid-high
  task automatic bit_io(input logic b, output logic got);
    tick(4);
    sda_drv <= b;
    tick(4);
    scl <= 1'b1;
    tick(4);
    got = sda_wire;
    tick(4);
    scl <= 1'b0;
  endtask : bit_io

  // also serves as repeated start from a low clock
  task automatic start;
    tick(4);
    sda_drv <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b0;
    tick(4);
    scl <= 1'b0;
  endtask : start

  task automatic stop;
    tick(4);
    sda_drv <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b1;
    tick(8);
  endtask : stop

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], g);
    end
    bit_io(1'b1, ack);
  endtask : wr_byte

  task automatic rd_byte(input logic ack_bit, output logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(ack_bit, g);
  endtask : rd_byte
endmodule : rtcs_master_model
`default_nettype wire

// ### verification/rtcs_slave_port_tb.sv
/*
  Self-checking bench for the slave port: register file model on CLOCK,
  bus master model paced by an unrelated link clock.
  Assumes the design's default slave address parameter.
*/
`timescale 1ns/100ps
`default_nettype none
module rtcs_slave_port_tb;
  import rtcs_pkg::*;
  logic clock = 1'b0;
  logic lclk = 1'b0;
  logic srst = 1'b1;
  logic scl;
  logic sda_drv;
  wire logic sda_wire;
  logic sda_out;
  logic sda_oe;
  logic [3:0] reg_ptr;
  logic [7:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic busy;
  logic [7:0] regs [16];
  wire logic [7:0] reg_rdata;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_read = 0;
  localparam logic [7:0] ADDR_W = {RTCS_SLAVE_ADDR_DEFAULT, 1'b0};
  localparam logic [7:0] ADDR_R = {RTCS_SLAVE_ADDR_DEFAULT, 1'b1};

  initial forever #10 clock = ~clock;
  initial forever #16 lclk = ~lclk;
  // pull-up wire: either party may pull low
  assign sda_wire = sda_drv & ~sda_oe;
  assign reg_rdata = regs[reg_ptr];

  // plain always: the initial block also fills the array before the run
  always @(posedge clock) begin
    if (reg_write) begin
      regs[reg_ptr] <= reg_wdata;
    end
    if (reg_read) begin
      n_read <= n_read + 1;
    end
  end

  rtcs_slave_port rtcs_slave_port_i (
    .CLOCK(clock), .SRST(srst), .SCL(scl), .SDA_IN(sda_wire), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .REG_PTR(reg_ptr), .REG_WDATA(reg_wdata), .REG_WRITE(reg_write),
    .REG_READ(reg_read), .REG_RDATA(reg_rdata), .BUSY(busy)
  );

  rtcs_master_model rtcs_master_model_i (
    .lclk(lclk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check8

  task automatic results;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////
  // pointer starts at 14 so the burst wraps past 15
  task automatic t_write;
    logic a;
    rtcs_master_model_i.start();
    rtcs_master_model_i.wr_byte(ADDR_W, a);
    check8("addr ack", 8'h00, {7'h00, a});
    rtcs_master_model_i.wr_byte(8'hfe, a);
    check8("word ack", 8'h00, {7'h00, a});
    check8("ptr", 8'h0e, {4'h0, reg_ptr});
    rtcs_master_model_i.wr_byte(8'ha5, a);
    check8("data ack", 8'h00, {7'h00, a});
    rtcs_master_model_i.wr_byte(8'h3c, a);
    rtcs_master_model_i.wr_byte(8'h96, a);
    check8("last ack", 8'h00, {7'h00, a});
    rtcs_master_model_i.stop();
    check8("reg e", 8'ha5, regs[14]);
    check8("reg f", 8'h3c, regs[15]);
    check8("reg 0", 8'h96, regs[0]);
    check8("ptr wrap", 8'h01, {4'h0, reg_ptr});
    check8("busy idle", 8'h00, {7'h00, busy});
    $display("test write done");
  endtask : t_write

  task automatic t_read;
    logic a;
    logic [7:0] d;
    rtcs_master_model_i.start();
    rtcs_master_model_i.wr_byte(ADDR_W, a);
    rtcs_master_model_i.wr_byte(8'h0e, a);
    rtcs_master_model_i.start();
    rtcs_master_model_i.wr_byte(ADDR_R, a);
    check8("rd addr ack", 8'h00, {7'h00, a});
    rtcs_master_model_i.rd_byte(1'b0, d);
    check8("rd 0", 8'ha5, d);
    rtcs_master_model_i.rd_byte(1'b0, d);
    check8("rd 1", 8'h3c, d);
    rtcs_master_model_i.rd_byte(1'b1, d);
    check8("rd 2", 8'h96, d);
    rtcs_master_model_i.tick(4);
    check8("released", 8'h00, {7'h00, sda_oe});
    check8("busy nack", 8'h00, {7'h00, busy});
    rtcs_master_model_i.stop();
    check8("ptr rd", 8'h01, {4'h0, reg_ptr});
    check8("read loads", 8'h03, n_read[7:0]);
    $display("test read done");
  endtask : t_read

  // a foreign address gets no acknowledge and no register access
  task automatic t_foreign;
    logic a;
    rtcs_master_model_i.start();
    rtcs_master_model_i.wr_byte(ADDR_W ^ 8'h02, a);
    check8("foreign ack", 8'h01, {7'h00, a});
    check8("foreign busy", 8'h00, {7'h00, busy});
    rtcs_master_model_i.wr_byte(8'h05, a);
    check8("foreign data", 8'h01, {7'h00, a});
    check8("ptr kept", 8'h01, {4'h0, reg_ptr});
    rtcs_master_model_i.stop();
    check8("sda out", 8'h00, {7'h00, sda_out});
    $display("test foreign done");
  endtask : t_foreign

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 16; i++) begin
      regs[i] = 8'h00;
    end
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    repeat (6) @(posedge clock);
    check8("ptr reset", 8'h00, {4'h0, reg_ptr});
    t_write();
    t_read();
    t_foreign();
    results();
  end

  // watchdog for a hung run
  initial begin
    repeat (100000) @(posedge clock);
    n_mismatch++;
    $display("unexpected timeout: expected done seen hang");
    results();
  end
endmodule : rtcs_slave_port_tb
`default_nettype wire
